// [hdl/sams_pkg.sv]
package sams_pkg;
    // =====================================================================
    // register map (byte addresses, one aligned word each)
    // =====================================================================
    localparam logic [15:0] MODE_OFF     = 16'hff28; // converter_mode_control
    localparam logic [15:0] RESULT_OFF   = 16'hff08; // result_word (16 bit)
    localparam logic [15:0] RESHI_OFF    = 16'hff0c; // result_high_byte
    localparam logic [15:0] STATUS_OFF   = 16'hff10; // sticky events, read clears
    localparam logic [15:0] MASK_OFF     = 16'hff14; // interrupt mask
    localparam logic [15:0] BITOP_OFF    = 16'hff18; // single-bit set/clear of mode
    // =====================================================================
    // mode register fields
    // =====================================================================
    localparam int          RUN_BIT      = 7;        // conversion_run
    localparam int          ZERO_BIT     = 6;        // always reads 0
    localparam int          DIV_LSB      = 3;        // divider_sel_2..0 at 5..3
    localparam int          LEN_LSB      = 1;        // sample_len_1..0 at 2..1
    localparam int          CMP_BIT      = 0;        // comparator_enable
    localparam logic [7:0]  MODE_RST     = 8'h00;    // mode reset value
    localparam logic [7:0]  MODE_WMASK   = 8'hbf;    // bit 6 not writable
    // bit operation word: bit 8 = set(1)/clear(0), bits 2..0 = bit number
    localparam int          BITOP_SET    = 8;
    // =====================================================================
    // status bits
    // =====================================================================
    localparam int          ST_DONE      = 0;        // conversion finished
    localparam int          ST_SUSPECT   = 1;        // first result not valid
    localparam int          ST_W         = 2;
    // =====================================================================
    // timing, in conversion-clock cycles
    // =====================================================================
    localparam logic [4:0]  CLR_CYC      = 5'h02;    // sar clear
    localparam logic [4:0]  SMP_SHORT    = 5'h06;    // sampling, field 00
    localparam logic [4:0]  SMP_LONG     = 5'h18;    // sampling, field 01
    localparam logic [4:0]  CMP_CYC      = 5'h0c;    // successive comparison
    localparam logic [4:0]  XFR_CYC      = 5'h02;    // transfer + interrupt
    localparam int          RES_W        = 10;       // sar width
    localparam int          RES_PAD      = 6;        // zero bits under result

    typedef enum logic [2:0] {
        SAMS_IDLE  = 3'b000,
        SAMS_CLEAR = 3'b001,
        SAMS_SAMP  = 3'b011,
        SAMS_COMP  = 3'b010,
        SAMS_XFER  = 3'b110
    } sams_state_e;

    // decoded mode register
    typedef struct packed {
        logic       run;
        logic [2:0] div;
        logic [1:0] len;
        logic       cmp;
    } sams_mode_s;

    // conversion-clock divide ratio for each divider code, 0 = prohibited
    function automatic logic [3:0] div_ratio(input logic [2:0] sel);
        case (sel)
            3'h0:    div_ratio = 4'hc;
            3'h1:    div_ratio = 4'h8;
            3'h2:    div_ratio = 4'h6;
            3'h3:    div_ratio = 4'h4;
            3'h4:    div_ratio = 4'h3;
            3'h5:    div_ratio = 4'h2;
            default: div_ratio = 4'h0;
        endcase
    endfunction
endpackage

// [hdl/sams_sequencer.sv]
// Added by the designer: the Wishbone slave port.
`timescale 1ns/10ps
`default_nettype none
// How it works
// - mode register resets zero, fixed bit layout
// - single-bit and full byte writes supported
// - run and comparator clear: fully stopped
// - comparator only: wait, no conversion
// - run converts continuously; no comparator flags first
// - run with comparator: repeated conversions, first result not flagged
// - mode write inserts one bus wait
// - divider 12,8,6,4,3,2; other codes prohibited
// - phases: clear 2, sample 6/24, compare 12, transfer 2
// - repeat conversion, interrupt each completion
// - result left-justified word plus high byte
// - sar resolves msb first down to lsb
module sams_sequencer (
    input  wire logic              clk_i,      // peripheral clock, 100 MHz
    input  wire logic              rst_i,      // synchronous reset, active high
    input  wire logic              cyc_i,      // wishbone cycle
    input  wire logic              stb_i,      // wishbone strobe
    input  wire logic              we_i,       // wishbone write enable
    input  wire logic [15:0]       adr_i,      // wishbone byte address
    input  wire logic [3:0]        sel_i,      // wishbone byte lanes
    input  wire logic [31:0]       dat_i,      // wishbone write data
    output logic      [31:0]       dat_o,      // wishbone read data
    output logic                   ack_o,      // wishbone acknowledge
    input  wire logic              cmp_hi_i,   // comparator: sample above trial
    output logic      [9:0]        trial_o,    // trial code to resistor string
    output logic                   sample_o,   // sample/hold tracking
    output logic                   cmp_on_o,   // comparator powered
    output logic                   irq_o       // level interrupt
);
    // =====================================================================
    // bus slave
    // =====================================================================
    logic [7:0]          mode_q, mode_d;       // converter_mode_control
    logic [15:0]         result_word_q, result_word_d;
    logic [7:0]          result_high_byte_q, result_high_byte_d;
    logic [1:0]          stat_q, stat_d;       // sticky events
    logic [1:0]          mask_q, mask_d;       // interrupt mask
    logic                ack_q, ack_d;
    logic [31:0]         rdat_q, rdat_d;
    logic                irq_q, irq_d;
    logic                done_ev, suspect_ev;  // events from sequencer
    logic                req;
    sams_pkg::sams_mode_s mode;

    assign req  = cyc_i && stb_i && !ack_q;
    assign mode = '{run: mode_q[sams_pkg::RUN_BIT],
                    div: mode_q[sams_pkg::DIV_LSB +: 3],
                    len: mode_q[sams_pkg::LEN_LSB +: 2],
                    cmp: mode_q[sams_pkg::CMP_BIT]};

    // register next values; ack one cycle after the request is seen
    always_comb begin
        mode_d             = mode_q;
        mask_d             = mask_q;
        stat_d             = stat_q;
        rdat_d             = 32'h0000_0000;
        ack_d              = req;                 // one wait cycle
        if (req && we_i && sel_i[0]) begin
            case (adr_i)
                sams_pkg::MODE_OFF:  mode_d = dat_i[7:0] & sams_pkg::MODE_WMASK;
                sams_pkg::BITOP_OFF: begin
                    // only the addressed bit changes
                    if (dat_i[2:0] != 3'(sams_pkg::ZERO_BIT)) begin
                        mode_d[dat_i[2:0]] = dat_i[sams_pkg::BITOP_SET];
                    end
                end
                sams_pkg::MASK_OFF:  mask_d = dat_i[1:0];
                default: ;                        // unmapped: ack, no effect
            endcase
        end
        if (req && !we_i) begin
            case (adr_i)
                sams_pkg::MODE_OFF:   rdat_d = {24'h0, mode_q};
                sams_pkg::RESULT_OFF: rdat_d = {16'h0, result_word_q};
                sams_pkg::RESHI_OFF:  rdat_d = {24'h0, result_high_byte_q};
                sams_pkg::STATUS_OFF: begin
                    rdat_d = {30'h0, stat_q};
                    stat_d = 2'b00;               // read clears
                end
                sams_pkg::MASK_OFF:   rdat_d = {30'h0, mask_q};
                default:              rdat_d = 32'h0000_0000;
            endcase
        end
        // hardware set wins over read clear
        if (done_ev) begin
            stat_d[sams_pkg::ST_DONE] = 1'b1;
        end
        if (suspect_ev) begin
            stat_d[sams_pkg::ST_SUSPECT] = 1'b1;
        end
        irq_d = |(stat_d & mask_d);
    end

    // bus and register flip-flops
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            mode_q <= sams_pkg::MODE_RST;
            mask_q <= 2'b00;
            stat_q <= 2'b00;
            ack_q  <= 1'b0;
            rdat_q <= 32'h0000_0000;
            irq_q  <= 1'b0;
        end else begin
            mode_q <= mode_d;
            mask_q <= mask_d;
            stat_q <= stat_d;
            ack_q  <= ack_d;
            rdat_q <= rdat_d;
            irq_q  <= irq_d;
        end
    end

    assign ack_o = ack_q;
    assign dat_o = rdat_q;
    assign irq_o = irq_q;

    // =====================================================================
    // conversion clock and sequencer
    // =====================================================================
    sams_pkg::sams_state_e st_q, st_d;
    logic [3:0]          pre_q, pre_d;         // prescaler
    logic [4:0]          cnt_q, cnt_d;         // phase counter in fad cycles
    logic [9:0]          sar_q, sar_d;
    logic [9:0]          bit_q, bit_d;         // one-hot trial bit
    logic                first_q, first_d;     // next result is first of run
    logic                samp_q, samp_d;
    logic                cmpon_q, cmpon_d;
    logic [9:0]          trial_q, trial_d;     // registered trial code to the string
    logic                tick;                 // one fad period elapsed
    logic                legal;                // divider and length allowed
    logic [3:0]          ratio;

    assign ratio = sams_pkg::div_ratio(mode.div);
    assign legal = (ratio != 4'h0) && !mode.len[1];
    assign tick  = (pre_q == ratio - 4'h1);

    // next state of the conversion sequence
    always_comb begin
        st_d       = st_q;
        pre_d      = tick ? 4'h0 : pre_q + 4'h1;
        cnt_d      = cnt_q;
        sar_d      = sar_q;
        bit_d      = bit_q;
        first_d    = first_q;
        done_ev    = 1'b0;
        suspect_ev = 1'b0;
        result_word_d      = result_word_q;
        result_high_byte_d = result_high_byte_q;
        cmpon_d    = mode.cmp || mode.run;
        if (!mode.run || !legal) begin
            // stopped, waiting or illegal divider/length: abort, nothing stored
            st_d    = sams_pkg::SAMS_IDLE;
            pre_d   = 4'h0;
            first_d = 1'b1;
        end else begin
            case (st_q)
                sams_pkg::SAMS_IDLE: begin
                    st_d  = sams_pkg::SAMS_CLEAR; // fresh start
                    cnt_d = sams_pkg::CLR_CYC;
                    pre_d = 4'h0;
                end
                sams_pkg::SAMS_CLEAR: begin
                    sar_d = 10'h000;
                    if (tick && cnt_q == 5'h01) begin
                        st_d  = sams_pkg::SAMS_SAMP;
                        cnt_d = mode.len[0] ? sams_pkg::SMP_LONG : sams_pkg::SMP_SHORT;
                    end else if (tick) begin
                        cnt_d = cnt_q - 5'h01;
                    end
                end
                sams_pkg::SAMS_SAMP: begin
                    if (tick && cnt_q == 5'h01) begin
                        st_d  = sams_pkg::SAMS_COMP;
                        cnt_d = sams_pkg::CMP_CYC;
                        bit_d = 10'h200;              // msb first
                    end else if (tick) begin
                        cnt_d = cnt_q - 5'h01;
                    end
                end
                sams_pkg::SAMS_COMP: begin
                    if (tick) begin
                        // ten steps decide bits, two settle
                        if (bit_q != 10'h000 && cmp_hi_i) begin
                            sar_d = sar_q | bit_q;
                        end
                        bit_d = bit_q >> 1;
                        cnt_d = cnt_q - 5'h01;
                        if (cnt_q == 5'h01) begin
                            st_d  = sams_pkg::SAMS_XFER;
                            cnt_d = sams_pkg::XFR_CYC;
                        end
                    end
                end
                sams_pkg::SAMS_XFER: begin
                    if (tick && cnt_q == 5'h01) begin
                        result_word_d = {sar_q, 6'h00};
                        result_high_byte_d = sar_q[9:2];
                        done_ev    = 1'b1;
                        suspect_ev = first_q && !mode.cmp;
                        first_d    = 1'b0;
                        st_d  = sams_pkg::SAMS_CLEAR;           // repeat
                        cnt_d = sams_pkg::CLR_CYC;
                    end else if (tick) begin
                        cnt_d = cnt_q - 5'h01;
                    end
                end
                default: st_d = sams_pkg::SAMS_IDLE;
            endcase
        end
        samp_d = (st_d == sams_pkg::SAMS_SAMP);
        // trial code leaves from a flop; it follows the sar with no extra lag
        trial_d = sar_d | bit_d;
    end

    // sequencer flip-flops
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            st_q    <= sams_pkg::SAMS_IDLE;
            pre_q   <= 4'h0;
            cnt_q   <= 5'h00;
            sar_q   <= 10'h000;
            bit_q   <= 10'h000;
            first_q <= 1'b1;
            samp_q  <= 1'b0;
            trial_q <= 10'h000;
            cmpon_q <= 1'b0;
            result_word_q      <= 16'h0000;
            result_high_byte_q <= 8'h00;
        end else begin
            st_q    <= st_d;
            pre_q   <= pre_d;
            cnt_q   <= cnt_d;
            sar_q   <= sar_d;
            bit_q   <= bit_d;
            first_q <= first_d;
            samp_q  <= samp_d;
            trial_q <= trial_d;
            cmpon_q <= cmpon_d;
            result_word_q      <= result_word_d;
            result_high_byte_q <= result_high_byte_d;
        end
    end

    assign trial_o  = trial_q;
    assign sample_o = samp_q;
    assign cmp_on_o = cmpon_q;

    // =====================================================================
    // assertions
    // =====================================================================
    a_mode_reset: assert property (@(posedge clk_i) $past(rst_i) |-> mode_q == 8'h00)
        else $error("mode not zero after reset");
    a_bit6_zero: assert property (@(posedge clk_i) disable iff (rst_i) !mode_q[6])
        else $error("mode bit 6 set");
    a_stop_off: assert property (@(posedge clk_i) disable iff (rst_i)
        (!mode.run && !mode.cmp) |=> (!cmp_on_o && st_q == sams_pkg::SAMS_IDLE))
        else $error("stopped converter still active");
    a_wait_mode: assert property (@(posedge clk_i) disable iff (rst_i)
        (!mode.run && mode.cmp) |=> (cmp_on_o && st_q == sams_pkg::SAMS_IDLE))
        else $error("waiting mode wrong");
    a_ack_wait: assert property (@(posedge clk_i) disable iff (rst_i)
        (cyc_i && stb_i && !ack_o) |=> ack_o)
        else $error("ack not after one wait");
    a_abort_clean: assert property (@(posedge clk_i) disable iff (rst_i)
        (!mode.run) |=> !done_ev && $stable(result_word_q))
        else $error("result changed while stopped");
    a_result_form: assert property (@(posedge clk_i) disable iff (rst_i)
        result_word_q[5:0] == 6'h00 && result_word_q[15:8] == result_high_byte_q)
        else $error("result registers disagree");
    a_bit_walk: assert property (@(posedge clk_i) disable iff (rst_i)
        (st_q == sams_pkg::SAMS_COMP && tick && mode.run && legal && bit_q != 10'h000)
        |=> bit_q == $past(bit_q) >> 1)
        else $error("sar bit order wrong");
    // comparator stays powered whenever run or comparator_enable is set
    a_cmp_power: assert property (@(posedge clk_i) disable iff (rst_i)
        (mode.run || mode.cmp) |=> cmp_on_o)
        else $error("comparator not powered");
    // a stopped converter never tracks the input
    a_stop_nosamp: assert property (@(posedge clk_i) disable iff (rst_i)
        (!mode.run) |=> !sample_o)
        else $error("sampling while stopped");
    // results only move in the transfer phase
    a_result_hold: assert property (@(posedge clk_i) disable iff (rst_i)
        (st_q != sams_pkg::SAMS_XFER) |=> $stable(result_word_q))
        else $error("result changed outside transfer");
    a_irq_level: assert property (@(posedge clk_i) disable iff (rst_i)
        done_ev && mask_q[0] |=> ##1 irq_o)
        else $error("interrupt missed");
    c_conversion: cover property (@(posedge clk_i) done_ev);
    c_suspect: cover property (@(posedge clk_i) suspect_ev);
    c_abort: cover property (@(posedge clk_i) st_q == sams_pkg::SAMS_COMP && !mode.run);
    // waiting mode and long sampling both get exercised
    c_waiting: cover property (@(posedge clk_i) !mode.run && mode.cmp && cmp_on_o);
    c_long_smp: cover property (@(posedge clk_i) st_q == sams_pkg::SAMS_SAMP && mode.len[0]);
endmodule
`default_nettype wire

// [verification/test_sams_sequencer.sv]
`timescale 1ns/10ps
`default_nettype none
`define CHK(nm, ex, got) begin comparisons++; if ((got) !== (ex)) begin error_cnt++; \
    $display("Error %s expected %h seen %h", nm, ex, got); end end
module test_sams_sequencer;
    // =====================================================================
    // stimulus and observation signals
    // =====================================================================
    logic        clk_i, rst_i, cyc_i, stb_i, we_i, cmp_hi_i;
    logic [15:0] adr_i;       // bus address
    logic [3:0]  sel_i;       // byte lanes, all on
    logic [31:0] dat_i;       // write data
    logic [31:0] dat_o;       // read data
    logic [31:0] rd;          // last read value
    logic        ack_o, sample_o, cmp_on_o, irq_o;
    logic [9:0]  trial_o;     // trial code from the sar
    logic [9:0]  target;      // analog level that the comparator model sees
    logic [9:0]  first_trial; // first trial code after sampling
    logic        seen_smp;    // sticky: sampling seen during idle()
    logic        seen_irq;    // sticky: interrupt seen during idle()
    int          error_cnt, comparisons, cycles;
    int          ratio[6] = '{12, 8, 6, 4, 3, 2}; // peripheral clocks per conversion clock

    sams_sequencer uut (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i),
        .we_i(we_i), .adr_i(adr_i), .sel_i(sel_i), .dat_i(dat_i), .dat_o(dat_o),
        .ack_o(ack_o), .cmp_hi_i(cmp_hi_i), .trial_o(trial_o), .sample_o(sample_o),
        .cmp_on_o(cmp_on_o), .irq_o(irq_o));

    // =====================================================================
    // clock, comparator model, trial capture, timeout
    // =====================================================================
    initial begin
        clk_i = 1'b0;
        forever #5 clk_i = ~clk_i;
    end
    // input above trial keeps the bit; one cycle lag is within a conversion clock
    always @(posedge clk_i) cmp_hi_i <= (target >= trial_o);
    // first nonzero trial code shows which bit the sar tries first
    always @(posedge clk_i) begin
        if (first_trial === 10'h0 && trial_o !== 10'h0) begin
            first_trial <= trial_o;
        end
    end
    // hang guard, far above the few thousand cycles the tests need
    always @(posedge clk_i) begin
        cycles++;
        if (cycles == 60000) begin
            error_cnt++;
            $display("Error timeout expected end seen hang");
            wrap_up();
        end
    end

    // =====================================================================
    // bus and helper tasks
    // =====================================================================
    task automatic wrap_up();
        $display("comparisons %0d errors %0d", comparisons, error_cnt);
        if (error_cnt == 0 && comparisons > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask
    // one classic cycle; request held until ack is sampled high at a rising edge
    task automatic wb(input logic w, input logic [15:0] a, input logic [31:0] d);
        int n;
        @(posedge clk_i);
        cyc_i <= 1'b1;
        stb_i <= 1'b1;
        we_i  <= w;
        adr_i <= a;
        dat_i <= d;
        n = 0;
        @(posedge clk_i);
        while (ack_o !== 1'b1 && n < 50) begin
            @(posedge clk_i);
            n++;
        end
        `CHK("ack", 1'b1, ack_o)
        rd = dat_o;
        cyc_i <= 1'b0;
        stb_i <= 1'b0;
        we_i  <= 1'b0;
    endtask
    task automatic rdchk(input logic [15:0] a, input logic [31:0] ex, input string nm);
        wb(1'b0, a, 32'h0);
        `CHK(nm, ex, rd)
    endtask
    // let n cycles pass, noting any sampling or interrupt
    task automatic idle(input int n);
        seen_smp = 1'b0;
        seen_irq = 1'b0;
        repeat (n) begin
            @(negedge clk_i);
            seen_smp |= sample_o;
            seen_irq |= irq_o;
        end
    endtask

    // =====================================================================
    // scenarios
    // =====================================================================
    task automatic t_reset();
        rdchk(sams_pkg::MODE_OFF, 32'h0, "mode");
        rdchk(sams_pkg::RESULT_OFF, 32'h0, "result_word");
        rdchk(sams_pkg::RESHI_OFF, 32'h0, "result_high");
        rdchk(16'hff00, 32'h0, "unmapped");
        `CHK("cmp_on", 1'b0, cmp_on_o)
        $display("test reset done");
    endtask
    task automatic t_mode();
        wb(1'b1, sams_pkg::MODE_OFF, 32'h7f);
        rdchk(sams_pkg::MODE_OFF, 32'h3f, "mode_fixed");
        idle(50);
        `CHK("cmp_wait", 1'b1, cmp_on_o)
        `CHK("no_sample", 1'b0, seen_smp)
        wb(1'b1, sams_pkg::BITOP_OFF, 32'h0);
        rdchk(sams_pkg::MODE_OFF, 32'h3e, "bit_clear");
        idle(3);
        `CHK("cmp_off", 1'b0, cmp_on_o)
        wb(1'b1, sams_pkg::BITOP_OFF, 32'h106);
        rdchk(sams_pkg::MODE_OFF, 32'h3e, "bit6_set");
        wb(1'b1, sams_pkg::BITOP_OFF, 32'h100);
        rdchk(sams_pkg::MODE_OFF, 32'h3f, "bit_set");
        $display("test mode done");
    endtask
    // one full conversion with the fields set while stopped
    task automatic t_conv(input logic [2:0] dv, input logic [1:0] ln, input logic cmpb,
                          input logic [9:0] tgt);
        int n;
        int w;
        logic [7:0] mh;
        mh = {2'b00, dv, ln, cmpb};
        target <= tgt;
        wb(1'b1, sams_pkg::MASK_OFF, 32'h3);
        wb(1'b1, sams_pkg::MODE_OFF, {24'h0, mh}); // fields change only while stopped
        wb(1'b0, sams_pkg::STATUS_OFF, 32'h0);
        wb(1'b1, sams_pkg::MODE_OFF, {24'h0, mh | 8'h80});
        for (n = 0; n < 1000 && sample_o !== 1'b1; n++) @(negedge clk_i);
        first_trial <= 10'h0;
        for (w = 0; w < 1000 && sample_o === 1'b1; w++) @(negedge clk_i);
        `CHK("sample_len", (ln == 2'b00 ? 6 : 24) * ratio[dv], w)
        for (n = 0; n < 1000 && irq_o !== 1'b1; n++) @(negedge clk_i);
        `CHK("irq_end", 1'b1, irq_o)
        wb(1'b1, sams_pkg::MODE_OFF, {24'h0, mh});
        rdchk(sams_pkg::STATUS_OFF, {30'h0, ~cmpb, 1'b1}, "status");
        rdchk(sams_pkg::RESULT_OFF, {16'h0, tgt, 6'h0}, "result");
        rdchk(sams_pkg::RESHI_OFF, {24'h0, tgt[9:2]}, "result_hi");
        `CHK("msb_first", 10'h200, first_trial)
        idle(2);
        `CHK("irq_clear", 1'b0, irq_o)
        $display("test conversion %0d done", dv);
    endtask
    task automatic t_abort();
        target <= 10'h155;
        wb(1'b1, sams_pkg::MASK_OFF, 32'h0);
        wb(1'b1, sams_pkg::MODE_OFF, 32'ha9);
        idle(120);
        `CHK("masked_irq", 1'b0, seen_irq)
        wb(1'b1, sams_pkg::MODE_OFF, 32'h29);
        rdchk(sams_pkg::STATUS_OFF, 32'h1, "masked_status");
        wb(1'b1, sams_pkg::MASK_OFF, 32'h3);
        target <= 10'h0aa;
        wb(1'b1, sams_pkg::MODE_OFF, 32'ha9);
        for (int n = 0; n < 500 && sample_o !== 1'b1; n++) @(negedge clk_i);
        for (int n = 0; n < 500 && sample_o === 1'b1; n++) @(negedge clk_i);
        idle(4);
        wb(1'b1, sams_pkg::MODE_OFF, 32'h29);
        idle(200);
        `CHK("abort_irq", 1'b0, seen_irq)
        `CHK("abort_smp", 1'b0, seen_smp)
        rdchk(sams_pkg::STATUS_OFF, 32'h0, "abort_status");
        rdchk(sams_pkg::RESULT_OFF, 32'h5540, "abort_keep");
        $display("test abort done");
    endtask
    task automatic t_illegal();
        wb(1'b1, sams_pkg::MODE_OFF, 32'hb1);
        idle(200);
        `CHK("div_110", 1'b0, seen_smp)
        wb(1'b1, sams_pkg::MODE_OFF, 32'h31);
        wb(1'b1, sams_pkg::MODE_OFF, 32'h2d);
        wb(1'b1, sams_pkg::MODE_OFF, 32'had);
        idle(200);
        `CHK("len_10", 1'b0, seen_smp)
        wb(1'b1, sams_pkg::MODE_OFF, 32'h2d);
        $display("test illegal done");
    endtask

    // =====================================================================
    // main sequence
    // =====================================================================
    initial begin
        rst_i = 1'b1;
        cyc_i = 1'b0;
        stb_i = 1'b0;
        we_i = 1'b0;
        adr_i = 16'h0;
        sel_i = 4'hf;
        dat_i = 32'h0;
        cmp_hi_i = 1'b0;
        target = 10'h0;
        first_trial = 10'h0;
        error_cnt = 0;
        comparisons = 0;
        cycles = 0;
        repeat (16) @(posedge clk_i);
        rst_i <= 1'b0;
        t_reset();
        t_mode();
        for (int d = 0; d < 6; d++) begin
            t_conv(d[2:0], 2'b00, 1'b1, 10'h2a5);
        end
        t_conv(3'h5, 2'b01, 1'b0, 10'h15a);
        t_conv(3'h4, 2'b00, 1'b1, 10'h3ff);
        t_conv(3'h5, 2'b00, 1'b1, 10'h000);
        t_abort();
        t_illegal();
        wrap_up();
    end
endmodule
`default_nettype wire
